//--- src/cst_defs.svh
// Register map, field positions, reset values and codes of the calibration control block
`ifndef CST_DEFS_SVH
`define CST_DEFS_SVH

// ==========================================================
// Register addresses
`define CST_ADDR_STATE_FLAGS 8'h6A
`define CST_ADDR_PIN_SETUP 8'h6B
`define CST_ADDR_SOFT_TRIG 8'h6C
`define CST_ADDR_CAL_CONTROL 8'h70
`define CST_ADDR_EVT_STATUS 8'h71
`define CST_ADDR_EVT_CLEAR 8'h72
`define CST_ADDR_EVT_ENABLE 8'h73

// ==========================================================
// Field positions
`define CST_FLAG_FG_BIT 0
`define CST_FLAG_HALT_BIT 1
`define CST_FLAG_CODE_LSB 2
`define CST_FLAG_CODE_MSB 4
`define CST_PIN_TRIG_SEL_BIT 0
`define CST_PIN_SRC_LSB 1
`define CST_PIN_SRC_MSB 2
`define CST_SOFT_TRIG_BIT 0
`define CST_CTRL_CAL_EN_BIT 0
`define CST_CTRL_BG_EN_BIT 1
`define CST_CTRL_LOWPOWER_TRIGGER_MODE_BIT 2

// ==========================================================
// Widths and codes
`define CST_EVT_W 3
`define CST_EVT_FG 0
`define CST_EVT_HALT 1
`define CST_EVT_ALARM 2
`define CST_SRC_FG 2'h0
`define CST_SRC_HALT 2'h1
`define CST_SRC_ALARM 2'h2
`define CST_SRC_LOW 2'h3

// ==========================================================
// Reset values
`define CST_RST_CODE 3'h0
`define CST_RST_SOFT_TRIG 1'h1
`define CST_RST_CAL_EN 1'h1
`define CST_RST_SYNC 1'h1
`define CST_RST_BYTE 8'h00
`define CST_RST_EVT 3'h0
`define CST_RST_LOW 1'h0

`endif

//--- src/cst_pkg.sv
// Types shared by the calibration control block
package cst_pkg;

    typedef enum logic [1:0] {
        CST_SRC_FG_E = 2'h0,
        CST_SRC_HALT_E = 2'h1,
        CST_SRC_ALARM_E = 2'h2,
        CST_SRC_LOW_E = 2'h3
    } cst_src_sel_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cst_bus_req_t;

    typedef struct packed {
        logic foreground_complete_flag_evt;
        logic fg_skip_evt;
        logic bg_stop_evt;
        logic cal_resume_evt;
        logic [2:0] cal_code;
        logic alarm;
    } cst_engine_in_t;

    typedef struct packed {
        logic s1;
        logic s2;
    } cst_sync_t;

    typedef struct packed {
        logic foreground_complete_flag;
        logic bg_halt;
        logic [2:0] code;
        logic trig_sel;
        cst_src_sel_t src_sel;
        logic soft_trig;
        logic cal_en;
        logic bg_en;
        logic lowpower_trigger_mode;
        logic [2:0] evt_stat;
        logic [2:0] evt_en;
        logic alarm_d;
        logic cal_trig;
        logic stat_pin;
        logic wake;
        logic irq;
        logic [7:0] rdata;
    } cst_state_t;

endpackage

//--- src/cst_trig_sync.sv
// Two-stage synchroniser for the hardware trigger pin
`timescale 1ns/1ps
`include "cst_defs.svh"

module cst_trig_sync
    import cst_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_async,
    output logic o_sync
);

    cst_sync_t st_r;
    cst_sync_t st_nxt;

    // ==========================================================
    // Stage chain, first stage feeds only the second
    always_comb
    begin
        st_nxt.s1 = i_async;
        st_nxt.s2 = st_r.s1;
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_r.s1 <= `CST_RST_SYNC;
            st_r.s2 <= `CST_RST_SYNC;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign o_sync = st_r.s2;

endmodule

//--- src/cst_calib_ctrl.sv
// Calibration status, status pin routing and calibration trigger selection
`timescale 1ns/1ps
`include "cst_defs.svh"

module cst_calib_ctrl
    import cst_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire cst_bus_req_t i_bus,
    output logic [7:0] o_rdata,
    input wire cst_engine_in_t i_engine,
    input wire logic i_hardware_trigger_pin,
    output logic o_status_output_pin,
    output logic o_cal_trigger,
    output logic o_core_wake,
    output logic o_cal_hold_rst,
    output logic o_div_rst,
    output logic o_irq
);

    cst_state_t st_r;
    cst_state_t st_nxt;
    logic hw_trig_sync;
    logic [2:0] evt_set;
    logic [2:0] evt_clr;
    logic halt_set;
    logic fg_set;

    // ==========================================================
    // Helpers
    function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
        hit = (a == t);
    endfunction

    function automatic logic src_mux(input cst_src_sel_t sel, input logic fg,
                                     input logic halt, input logic alarm);
        case (sel)
            CST_SRC_FG_E: src_mux = fg;
            CST_SRC_HALT_E: src_mux = halt;
            CST_SRC_ALARM_E: src_mux = alarm;
            CST_SRC_LOW_E: src_mux = 1'h0;
            default: src_mux = 1'h0;
        endcase
    endfunction

    // ==========================================================
    // Hardware trigger synchroniser
    cst_trig_sync u_trig_sync (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_async(i_hardware_trigger_pin),
        .o_sync(hw_trig_sync)
    );

    // ==========================================================
    // Next state
    always_comb
    begin
        st_nxt = st_r;
        // Flags
        fg_set = i_engine.foreground_complete_flag_evt | i_engine.fg_skip_evt;
        halt_set = i_engine.bg_stop_evt | (~st_r.bg_en & fg_set);
        if (fg_set)
        begin
            st_nxt.foreground_complete_flag = 1'h1;
        end
        else if (!st_r.cal_en)
        begin
            st_nxt.foreground_complete_flag = 1'h0;
        end
        if (halt_set)
        begin
            st_nxt.bg_halt = 1'h1;
        end
        else if (i_engine.cal_resume_evt || !st_r.cal_en)
        begin
            st_nxt.bg_halt = 1'h0;
        end
        st_nxt.code = st_r.cal_en ? i_engine.cal_code : `CST_RST_CODE;
        st_nxt.alarm_d = i_engine.alarm;
        // Register writes
        evt_clr = `CST_RST_EVT;
        if (i_bus.wr)
        begin
            if (hit(i_bus.addr, `CST_ADDR_PIN_SETUP))
            begin
                st_nxt.trig_sel = i_bus.wdata[`CST_PIN_TRIG_SEL_BIT];
                st_nxt.src_sel = cst_src_sel_t'(i_bus.wdata[`CST_PIN_SRC_MSB:`CST_PIN_SRC_LSB]);
            end
            if (hit(i_bus.addr, `CST_ADDR_SOFT_TRIG))
            begin
                st_nxt.soft_trig = i_bus.wdata[`CST_SOFT_TRIG_BIT];
            end
            if (hit(i_bus.addr, `CST_ADDR_CAL_CONTROL))
            begin
                st_nxt.cal_en = i_bus.wdata[`CST_CTRL_CAL_EN_BIT];
                st_nxt.bg_en = i_bus.wdata[`CST_CTRL_BG_EN_BIT];
                st_nxt.lowpower_trigger_mode = i_bus.wdata[`CST_CTRL_LOWPOWER_TRIGGER_MODE_BIT];
            end
            if (hit(i_bus.addr, `CST_ADDR_EVT_CLEAR))
            begin
                evt_clr = i_bus.wdata[`CST_EVT_W-1:0];
            end
            if (hit(i_bus.addr, `CST_ADDR_EVT_ENABLE))
            begin
                st_nxt.evt_en = i_bus.wdata[`CST_EVT_W-1:0];
            end
        end
        // Events, a new event wins over a clear
        evt_set = `CST_RST_EVT;
        evt_set[`CST_EVT_FG] = ~st_r.foreground_complete_flag & st_nxt.foreground_complete_flag;
        evt_set[`CST_EVT_HALT] = ~st_r.bg_halt & st_nxt.bg_halt;
        evt_set[`CST_EVT_ALARM] = ~st_r.alarm_d & st_nxt.alarm_d;
        for (int i = 0; i < `CST_EVT_W; i++)
        begin
            st_nxt.evt_stat[i] = evt_set[i] | (st_r.evt_stat[i] & ~evt_clr[i]);
        end
        st_nxt.irq = |(st_nxt.evt_stat & st_nxt.evt_en);
        // Trigger and pin
        st_nxt.cal_trig = st_nxt.trig_sel ? hw_trig_sync : st_nxt.soft_trig;
        st_nxt.wake = st_nxt.lowpower_trigger_mode & ~st_nxt.cal_trig;
        st_nxt.stat_pin = src_mux(st_nxt.src_sel, st_nxt.foreground_complete_flag, st_nxt.bg_halt,
                                  st_nxt.alarm_d);
        // Read data, valid in the cycle after the strobe only
        st_nxt.rdata = `CST_RST_BYTE;
        if (i_bus.rd)
        begin
            if (hit(i_bus.addr, `CST_ADDR_STATE_FLAGS))
            begin
                st_nxt.rdata[`CST_FLAG_FG_BIT] = st_r.foreground_complete_flag;
                st_nxt.rdata[`CST_FLAG_HALT_BIT] = st_r.bg_halt;
                st_nxt.rdata[`CST_FLAG_CODE_MSB:`CST_FLAG_CODE_LSB] = st_r.code;
            end
            if (hit(i_bus.addr, `CST_ADDR_PIN_SETUP))
            begin
                st_nxt.rdata[`CST_PIN_TRIG_SEL_BIT] = st_r.trig_sel;
                st_nxt.rdata[`CST_PIN_SRC_MSB:`CST_PIN_SRC_LSB] = st_r.src_sel;
            end
            if (hit(i_bus.addr, `CST_ADDR_SOFT_TRIG))
            begin
                st_nxt.rdata[`CST_SOFT_TRIG_BIT] = st_r.soft_trig;
            end
            if (hit(i_bus.addr, `CST_ADDR_CAL_CONTROL))
            begin
                st_nxt.rdata[`CST_CTRL_CAL_EN_BIT] = st_r.cal_en;
                st_nxt.rdata[`CST_CTRL_BG_EN_BIT] = st_r.bg_en;
                st_nxt.rdata[`CST_CTRL_LOWPOWER_TRIGGER_MODE_BIT] = st_r.lowpower_trigger_mode;
            end
            if (hit(i_bus.addr, `CST_ADDR_EVT_STATUS))
            begin
                st_nxt.rdata[`CST_EVT_W-1:0] = st_r.evt_stat;
            end
            if (hit(i_bus.addr, `CST_ADDR_EVT_ENABLE))
            begin
                st_nxt.rdata[`CST_EVT_W-1:0] = st_r.evt_en;
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_r.foreground_complete_flag <= `CST_RST_LOW;
            st_r.bg_halt <= `CST_RST_LOW;
            st_r.code <= `CST_RST_CODE;
            st_r.trig_sel <= `CST_RST_LOW;
            st_r.src_sel <= CST_SRC_FG_E;
            st_r.soft_trig <= `CST_RST_SOFT_TRIG;
            st_r.cal_en <= `CST_RST_CAL_EN;
            st_r.bg_en <= `CST_RST_LOW;
            st_r.lowpower_trigger_mode <= `CST_RST_LOW;
            st_r.evt_stat <= `CST_RST_EVT;
            st_r.evt_en <= `CST_RST_EVT;
            st_r.alarm_d <= `CST_RST_LOW;
            st_r.cal_trig <= `CST_RST_SOFT_TRIG;
            st_r.stat_pin <= `CST_RST_LOW;
            st_r.wake <= `CST_RST_LOW;
            st_r.irq <= `CST_RST_LOW;
            st_r.rdata <= `CST_RST_BYTE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign o_rdata = st_r.rdata;
    assign o_status_output_pin = st_r.stat_pin;
    assign o_cal_trigger = st_r.cal_trig;
    assign o_core_wake = st_r.wake;
    assign o_cal_hold_rst = ~st_r.cal_en;
    assign o_div_rst = ~st_r.cal_en;
    assign o_irq = st_r.irq;

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_status_read;
        i_bus.rd && hit(i_bus.addr, `CST_ADDR_STATE_FLAGS);
    endsequence

    sequence s_hw_sel_held;
        st_r.trig_sel [*4];
    endsequence

    sequence s_soft_sel_write(logic v);
        i_bus.wr && hit(i_bus.addr, `CST_ADDR_SOFT_TRIG) &&
            i_bus.wdata[`CST_SOFT_TRIG_BIT] == v && !st_r.trig_sel;
    endsequence

    chk_halt_on_stop: assert property (
        i_engine.bg_stop_evt |=> st_r.bg_halt ##1 (st_r.bg_halt || $past(i_engine.cal_resume_evt)
            || !$past(st_r.cal_en)))
        else $error("halt flag not set after background stop");

    chk_halt_on_resume: assert property (
        (i_engine.cal_resume_evt && !i_engine.bg_stop_evt &&
            !(!st_r.bg_en && (i_engine.foreground_complete_flag_evt || i_engine.fg_skip_evt)))
        |=> !st_r.bg_halt)
        else $error("halt flag not cleared on resume");

    chk_halt_fg_bgoff: assert property (
        (!st_r.bg_en && (i_engine.foreground_complete_flag_evt || i_engine.fg_skip_evt)) |=> st_r.bg_halt)
        else $error("halt flag not set by foreground end with background off");

    chk_fg_flag_set: assert property (
        (i_engine.foreground_complete_flag_evt || i_engine.fg_skip_evt) |=> st_r.foreground_complete_flag && st_r.rdata == 8'h00
            || st_r.foreground_complete_flag)
        else $error("foreground flag not set");

    chk_status_code_read: assert property (
        s_status_read |=> o_rdata[`CST_FLAG_CODE_MSB:`CST_FLAG_CODE_LSB] == $past(st_r.code)
            && o_rdata[7:5] == 3'h0 && o_rdata[`CST_FLAG_FG_BIT] == $past(st_r.foreground_complete_flag))
        else $error("status read does not match flags");

    chk_pin_src_fg: assert property (
        st_r.src_sel == CST_SRC_FG_E |-> o_status_output_pin == st_r.foreground_complete_flag)
        else $error("status pin does not follow foreground flag");

    chk_pin_src_halt: assert property (
        st_r.src_sel == CST_SRC_HALT_E |-> o_status_output_pin == st_r.bg_halt)
        else $error("status pin does not follow halt flag");

    chk_pin_src_alarm: assert property (
        (st_r.src_sel == CST_SRC_ALARM_E && $stable(st_r.src_sel))
        |-> o_status_output_pin == $past(i_engine.alarm))
        else $error("status pin does not follow alarm");

    chk_pin_src_low: assert property (
        st_r.src_sel == CST_SRC_LOW_E |-> !o_status_output_pin)
        else $error("status pin not low");

    chk_trig_soft_path: assert property (
        s_soft_sel_write(1'h0) ##1 !st_r.trig_sel |-> !o_cal_trigger)
        else $error("software trigger bit not used");

    chk_trig_hw_path: assert property (
        s_hw_sel_held |-> o_cal_trigger == $past(i_hardware_trigger_pin, 3))
        else $error("hardware trigger pin not used after two stages");

    chk_wake_lowpower: assert property (
        o_core_wake == (st_r.lowpower_trigger_mode && !o_cal_trigger))
        else $error("core wake does not follow low trigger");

    chk_cal_hold_flags: assert property (
        (!st_r.cal_en && !i_engine.foreground_complete_flag_evt && !i_engine.fg_skip_evt)
        |-> o_cal_hold_rst && o_div_rst ##1 !st_r.foreground_complete_flag)
        else $error("calibration hold does not reset state");

    chk_irq_level: assert property (
        (|(st_r.evt_stat & st_r.evt_en)) == o_irq)
        else $error("interrupt output disagrees with enabled status");

    chk_trig_soft_sel: assert property (
        !st_r.trig_sel |-> o_cal_trigger == st_r.soft_trig)
        else $error("trigger does not follow software bit");

    chk_trig_hw_sel: assert property (
        st_r.trig_sel |-> o_cal_trigger == $past(hw_trig_sync))
        else $error("trigger does not follow synchronised pin");

    chk_code_follow: assert property (
        st_r.cal_en |=> st_r.code == $past(i_engine.cal_code))
        else $error("status code does not follow engine");

    chk_code_cal_off: assert property (
        !st_r.cal_en |=> st_r.code == `CST_RST_CODE)
        else $error("status code not cleared while calibration held");

    chk_read_idle: assert property (
        !i_bus.rd |=> o_rdata == `CST_RST_BYTE)
        else $error("read data stands longer than one cycle");

    chk_pin_setup_write: assert property (
        i_bus.wr && hit(i_bus.addr, `CST_ADDR_PIN_SETUP)
        |=> st_r.trig_sel == $past(i_bus.wdata[`CST_PIN_TRIG_SEL_BIT]))
        else $error("trigger select not written");

    chk_soft_trig_write: assert property (
        i_bus.wr && hit(i_bus.addr, `CST_ADDR_SOFT_TRIG)
        |=> st_r.soft_trig == $past(i_bus.wdata[`CST_SOFT_TRIG_BIT]))
        else $error("software trigger bit not written");

    chk_fg_evt_set: assert property (
        (!st_r.foreground_complete_flag && (i_engine.foreground_complete_flag_evt || i_engine.fg_skip_evt))
        |=> st_r.evt_stat[`CST_EVT_FG])
        else $error("foreground event not recorded");

    chk_halt_evt_set: assert property (
        (!st_r.bg_halt && halt_set) |=> st_r.evt_stat[`CST_EVT_HALT])
        else $error("halt event not recorded");

    chk_alarm_evt_set: assert property (
        (!st_r.alarm_d && i_engine.alarm) |=> st_r.evt_stat[`CST_EVT_ALARM])
        else $error("alarm event not recorded");

    chk_evt_sticky: assert property (
        (st_r.evt_stat != `CST_RST_EVT && !(i_bus.wr && hit(i_bus.addr, `CST_ADDR_EVT_CLEAR)))
        |=> (st_r.evt_stat & $past(st_r.evt_stat)) == $past(st_r.evt_stat))
        else $error("event status bit lost without a clear");

endmodule

//--- verification/cst_host_model.sv
// Host controller model that drives the calibration trigger pin
`timescale 1ns/1ps

module cst_host_model
(
    input wire logic i_core_clk,
    input wire logic i_level,
    input wire logic i_slow,
    output logic o_hardware_trigger_pin
);
    // ==========================================================
    // Pin driver, on the next edge or on the fourth edge after a level change
    logic pin_r = 1'b1;
    logic [2:0] delay_r = 3'h0;

    assign o_hardware_trigger_pin = pin_r;

    always @(posedge i_core_clk)
    begin
        if (i_level == pin_r)
            delay_r <= 3'h0;
        else if (!i_slow || delay_r == 3'h3)
            pin_r <= i_level;
        else
            delay_r <= delay_r + 3'h1;
    end
endmodule

//--- verification/tb_top.sv
// Self-checking testbench for the calibration control block
`timescale 1ns/1ps
`include "cst_defs.svh"

module tb_top
    import cst_pkg::*;
;
    logic i_core_clk;
    logic i_rst;
    cst_bus_req_t bus;
    cst_engine_in_t eng;
    logic host_level;
    logic host_slow;
    logic hw_pin;
    logic [7:0] rdata;
    logic stat_pin;
    logic cal_trig;
    logic core_wake;
    logic hold_rst;
    logic div_rst;
    logic irq;
    logic [7:0] rd_val;
    int error_cnt = 0;
    int check_count = 0;
    int cycle_cnt = 0;

    cst_calib_ctrl cst_calib_ctrl_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_bus(bus),
        .o_rdata(rdata), .i_engine(eng), .i_hardware_trigger_pin(hw_pin),
        .o_status_output_pin(stat_pin), .o_cal_trigger(cal_trig), .o_core_wake(core_wake),
        .o_cal_hold_rst(hold_rst), .o_div_rst(div_rst), .o_irq(irq));

    cst_host_model cst_host_model_inst (.i_core_clk(i_core_clk), .i_level(host_level),
        .i_slow(host_slow), .o_hardware_trigger_pin(hw_pin));

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        check_count++;
        if (act !== exp)
        begin
            error_cnt++;
            $display("MISMATCH at %0t: got 0x%0h expected 0x%0h", $time, act, exp);
        end
    endtask

    task automatic chk_bit(input logic act, input logic exp);
        chk({7'h00, act}, {7'h00, exp});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask

    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_core_clk);
        bus.addr <= addr;
        bus.wdata <= data;
        bus.wr <= 1'b1;
        @(posedge i_core_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge i_core_clk);
        bus.addr <= addr;
        bus.rd <= 1'b1;
        @(posedge i_core_clk);
        bus.rd <= 1'b0;
        #1;
        rd_val = rdata;
        chk(rd_val, exp);
    endtask

    task automatic pulse(input int which);
        @(posedge i_core_clk);
        eng.foreground_complete_flag_evt <= (which == 0);
        eng.fg_skip_evt <= (which == 1);
        eng.bg_stop_evt <= (which == 2);
        eng.cal_resume_evt <= (which == 3);
        @(posedge i_core_clk);
        eng.foreground_complete_flag_evt <= 1'b0;
        eng.fg_skip_evt <= 1'b0;
        eng.bg_stop_evt <= 1'b0;
        eng.cal_resume_evt <= 1'b0;
        wait_cyc(2);
    endtask

    task automatic trig_step(input logic lvl, input logic slow);
        int n;
        n = 0;
        @(posedge i_core_clk);
        host_slow <= slow;
        host_level <= lvl;
        while (hw_pin !== lvl && n < 20)
        begin
            wait_cyc(1);
            n++;
        end
        n = 0;
        while (cal_trig !== lvl && n < 8)
        begin
            wait_cyc(1);
            n++;
        end
        chk(8'(n), 8'h03);
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_reset;
        rd_chk(`CST_ADDR_STATE_FLAGS, 8'h00);
        rd_chk(`CST_ADDR_PIN_SETUP, 8'h00);
        rd_chk(`CST_ADDR_SOFT_TRIG, 8'h01);
        reg_wr(8'h55, 8'hFF);
        rd_chk(8'h55, 8'h00);
        chk_bit(cal_trig, 1'b1);
        chk_bit(stat_pin, 1'b0);
        $display("test_reset done");
    endtask

    task automatic test_flags;
        @(posedge i_core_clk);
        eng.cal_code <= 3'h5;
        pulse(0);
        rd_chk(`CST_ADDR_STATE_FLAGS, 8'h17);
        chk_bit(stat_pin, 1'b1);
        reg_wr(`CST_ADDR_STATE_FLAGS, 8'hFF);
        pulse(3);
        rd_chk(`CST_ADDR_STATE_FLAGS, 8'h15);
        reg_wr(`CST_ADDR_CAL_CONTROL, 8'h03);
        pulse(2);
        rd_chk(`CST_ADDR_STATE_FLAGS, 8'h17);
        reg_wr(`CST_ADDR_CAL_CONTROL, 8'h00);
        wait_cyc(2);
        chk_bit(hold_rst, 1'b1);
        chk_bit(div_rst, 1'b1);
        rd_chk(`CST_ADDR_STATE_FLAGS, 8'h00);
        reg_wr(`CST_ADDR_CAL_CONTROL, 8'h01);
        pulse(1);
        rd_chk(`CST_ADDR_STATE_FLAGS, 8'h17);
        chk_bit(hold_rst, 1'b0);
        $display("test_flags done");
    endtask

    task automatic test_src;
        logic [3:0] exp_tab [2] = '{4'h5, 4'h3};
        for (int p = 0; p < 2; p++)
        begin
            @(posedge i_core_clk);
            eng.alarm <= (p == 0);
            pulse(p == 0 ? 3 : 1);
            for (int s = 0; s < 4; s++)
            begin
                reg_wr(`CST_ADDR_PIN_SETUP, {5'h00, s[1:0], 1'b0});
                wait_cyc(3);
                chk_bit(stat_pin, exp_tab[p][s]);
            end
        end
        reg_wr(`CST_ADDR_PIN_SETUP, 8'h00);
        $display("test_src done");
    endtask

    task automatic test_trig;
        reg_wr(`CST_ADDR_SOFT_TRIG, 8'h00);
        wait_cyc(3);
        chk_bit(cal_trig, 1'b0);
        reg_wr(`CST_ADDR_PIN_SETUP, 8'h01);
        wait_cyc(4);
        chk_bit(cal_trig, 1'b1);
        reg_wr(`CST_ADDR_CAL_CONTROL, 8'h05);
        trig_step(1'b0, 1'b0);
        chk_bit(core_wake, 1'b1);
        reg_wr(`CST_ADDR_SOFT_TRIG, 8'h01);
        wait_cyc(3);
        chk_bit(cal_trig, 1'b0);
        trig_step(1'b1, 1'b1);
        chk_bit(core_wake, 1'b0);
        reg_wr(`CST_ADDR_CAL_CONTROL, 8'h01);
        reg_wr(`CST_ADDR_PIN_SETUP, 8'h00);
        @(posedge i_core_clk);
        host_level <= 1'b0;
        wait_cyc(10);
        chk_bit(cal_trig, 1'b1);
        @(posedge i_core_clk);
        host_level <= 1'b1;
        $display("test_trig done");
    endtask

    task automatic test_irq;
        reg_wr(`CST_ADDR_CAL_CONTROL, 8'h00);
        reg_wr(`CST_ADDR_CAL_CONTROL, 8'h01);
        reg_wr(`CST_ADDR_EVT_ENABLE, 8'h01);
        reg_wr(`CST_ADDR_EVT_CLEAR, 8'h07);
        wait_cyc(2);
        chk_bit(irq, 1'b0);
        pulse(0);
        chk_bit(irq, 1'b1);
        rd_chk(`CST_ADDR_EVT_STATUS, 8'h03);
        reg_wr(`CST_ADDR_EVT_ENABLE, 8'h04);
        wait_cyc(2);
        chk_bit(irq, 1'b0);
        @(posedge i_core_clk);
        eng.alarm <= 1'b1;
        wait_cyc(3);
        chk_bit(irq, 1'b1);
        reg_wr(`CST_ADDR_EVT_CLEAR, 8'h04);
        wait_cyc(2);
        chk_bit(irq, 1'b0);
        rd_chk(`CST_ADDR_EVT_STATUS, 8'h03);
        rd_chk(`CST_ADDR_EVT_ENABLE, 8'h04);
        $display("test_irq done");
    endtask

    task automatic test_rst_mid;
        reg_wr(`CST_ADDR_SOFT_TRIG, 8'h00);
        @(posedge i_core_clk);
        i_rst <= 1'b1;
        wait_cyc(2);
        chk_bit(cal_trig, 1'b1);
        chk_bit(irq, 1'b0);
        chk(rdata, 8'h00);
        @(posedge i_core_clk);
        i_rst <= 1'b0;
        rd_chk(`CST_ADDR_SOFT_TRIG, 8'h01);
        rd_chk(`CST_ADDR_EVT_ENABLE, 8'h00);
        $display("test_rst_mid done");
    endtask

    // ==========================================================
    // Clock, sequence, watchdog and verdict
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end

    initial
    begin
        i_rst = 1'b1;
        bus = '0;
        eng = '0;
        host_level = 1'b1;
        host_slow = 1'b0;
        repeat (12) @(posedge i_core_clk);
        i_rst <= 1'b0;
        test_reset;
        test_flags;
        test_src;
        test_trig;
        test_irq;
        test_rst_mid;
        conclude;
    end

    always @(posedge i_core_clk)
    begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 3000)
        begin
            error_cnt++;
            conclude;
        end
    end
endmodule
